// ==== src/mcd_defs.svh ====
// constants for the translation and cache debug control block
`ifndef MCD_DEFS_SVH
`define MCD_DEFS_SVH

// coprocessor operation selectors (crn is always 15)
`define MCD_CRN_DEBUG        4'hf
`define MCD_OPC1_TEST        3'h0
`define MCD_OPC1_LOCK_A      3'h4
`define MCD_OPC1_LOCK_B      3'h5
`define MCD_OPC1_DEBUG       3'h7
`define MCD_CRM_SELECT       4'h1
`define MCD_CRM_REMAP        4'h2
`define MCD_CRM_TAG_RD       4'h2
`define MCD_CRM_TAG_WR       4'h3
`define MCD_CRM_PA_RD        4'h4
`define MCD_CRM_PA_WR        4'h5
`define MCD_CRM_XFER         4'h7
`define MCD_CRM_CACHE_DBG    4'h0
`define MCD_CRM_MMU_DBG      4'h1
`define MCD_OPC2_PLAIN       3'h0
`define MCD_OPC2_LOCK        3'h1

// entry select word
`define MCD_SEL_IDX_HI       28
`define MCD_SEL_IDX_LO       26

// cache debug control fields
`define MCD_CDC_D_FILL_OFF   0
`define MCD_CDC_I_FILL_OFF   1
`define MCD_CDC_FWT          2
`define MCD_CDC_W            3
`define MCD_CDC_RST          3'h0

// translation debug control fields
`define MCD_TDC_D_MICRO_LOAD  0
`define MCD_TDC_I_MICRO_LOAD  1
`define MCD_TDC_D_MICRO_MATCH 2
`define MCD_TDC_I_MICRO_MATCH 3
`define MCD_TDC_D_MAIN_LOAD   4
`define MCD_TDC_I_MAIN_LOAD   5
`define MCD_TDC_D_MAIN_MATCH  6
`define MCD_TDC_I_MAIN_MATCH  7
`define MCD_TDC_W            8
`define MCD_TDC_RST          8'h00

// remap register: data side in 7:0, instruction side in 15:8
`define MCD_REMAP_W          16
`define MCD_REMAP_RST        16'he4e4
`define MCD_REMAP_DATA_LO    0
`define MCD_REMAP_INSTR_LO   8

// tag word fields
`define MCD_TAG_VALID        4

// data ram
`define MCD_RAM_W            112
`define MCD_RAM_HALF_W       56
`define MCD_LANES_ALL        4'hf
`define MCD_LANES_NONE       4'h0
`define MCD_LANE0_HI         29
`define MCD_LANE1_HI         55
`define MCD_LANE2_LO         57
`define MCD_LANE2_HI         85
`define MCD_LANE3_LO         86

`endif

// ==== src/mcd_pkg.sv ====
// types of the translation and cache debug control block
package mcd_pkg;

  typedef enum logic [1:0]
  {
    MCD_NCNB = 2'h0,
    MCD_NCB  = 2'h1,
    MCD_WT   = 2'h2,
    MCD_WB   = 2'h3
  } mcd_attr_e;

  typedef enum logic [1:0]
  {
    MCD_IDLE,
    MCD_WRITE,
    MCD_READ,
    MCD_SAMPLE
  } mcd_state_e;

  typedef logic [2:0] mcd_idx_t;

endpackage

// ==== src/mcd_attr_resolve.sv ====
// memory attribute resolution and cache write/fill policy
`timescale 1ns/1ps
`include "mcd_defs.svh"

module mcd_attr_resolve
(
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire logic [15:0]              i_remap,
  input  wire logic                     i_force_write_through,
  input  wire logic                     i_instr_linefill_disable,
  input  wire logic                     i_data_linefill_disable,
  input  wire mcd_pkg::mcd_attr_e       i_instr_cb,
  input  wire mcd_pkg::mcd_attr_e       i_data_cb,
  input  wire logic                     i_d_write_hit,
  output mcd_pkg::mcd_attr_e            o_instr_attr,
  output mcd_pkg::mcd_attr_e            o_data_attr,
  output logic                          o_d_set_dirty,
  output logic                          o_d_write_mem,
  output logic                          o_i_fill_update,
  output logic                          o_d_fill_update
);
  import mcd_pkg::*;

  mcd_attr_e i_attr;
  mcd_attr_e d_attr;

  // 4-entry lookup: page class selects one 2-bit field of a side
  function automatic mcd_attr_e remap_lookup(input logic [7:0] side, input mcd_attr_e cls);
    logic [1:0] f;
    f = 2'h0;
    case (cls)
      MCD_NCNB: f = side[1:0];
      MCD_NCB:  f = side[3:2];
      MCD_WT:   f = side[5:4];
      MCD_WB:   f = side[7:6];
      default:  f = side[1:0];
    endcase
    return mcd_attr_e'(f);
  endfunction

  function automatic logic cachable(input mcd_attr_e a);
    return a[1];
  endfunction

  always_comb
  begin
    i_attr = remap_lookup(i_remap[`MCD_REMAP_INSTR_LO +: 8], i_instr_cb);
    d_attr = remap_lookup(i_remap[`MCD_REMAP_DATA_LO +: 8], i_data_cb);
    // forced write-through beats page tables and remap on the data side, when the remapped class is cachable
    if (i_force_write_through && cachable(d_attr))
    begin
      d_attr = MCD_WT;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_instr_attr <= MCD_NCNB;
      o_data_attr  <= MCD_NCNB;
    end
    else
    begin
      o_instr_attr <= i_attr;
      o_data_attr  <= d_attr;
    end
  end

  // dirty flags are only ever set here; cleaning stays with eviction and clean ops
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_d_set_dirty <= 1'b0;
      o_d_write_mem <= 1'b0;
    end
    else
    begin
      o_d_set_dirty <= i_d_write_hit && (d_attr == MCD_WB);
      o_d_write_mem <= i_d_write_hit && (d_attr == MCD_WT);
    end
  end

  // the fill still runs (eight words) on a miss; only the array update is dropped
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_i_fill_update <= 1'b0;
      o_d_fill_update <= 1'b0;
    end
    else
    begin
      o_i_fill_update <= cachable(i_attr) && !i_instr_linefill_disable;
      o_d_fill_update <= cachable(d_attr) && !i_data_linefill_disable;
    end
  end

  fwt_to_wt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_force_write_through && cachable(d_attr)) |=> (o_data_attr == MCD_WT))
    else $error("forced write-through not applied");

  fwt_no_dirty_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_force_write_through |=> !o_d_set_dirty)
    else $error("dirty set while write-through forced");

  fill_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_data_linefill_disable || i_instr_linefill_disable) |=>
      !((o_d_fill_update && $past(i_data_linefill_disable)) ||
        (o_i_fill_update && $past(i_instr_linefill_disable))))
    else $error("linefill updated cache while disabled");

endmodule

// ==== src/mcd_debug_ctrl.sv ====
// translation and cache debug control with lockdown tlb test access
`timescale 1ns/1ps
`include "mcd_defs.svh"

module mcd_debug_ctrl
(
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_cp_req,
  input  wire logic                     i_cp_write,
  input  wire logic [3:0]               i_cp_crn,
  input  wire logic [2:0]               i_cp_opc1,
  input  wire logic [3:0]               i_cp_crm,
  input  wire logic [2:0]               i_cp_opc2,
  input  wire logic [31:0]              i_cp_wdata,
  output logic                          o_cp_ready,
  output logic                          o_cp_done,
  output logic [31:0]                   o_cp_rdata,
  output logic                          o_tlb_ram_select,
  output logic [3:0]                    o_tlb_ram_lane_write_enable,
  output mcd_pkg::mcd_idx_t             o_tlb_ram_index,
  output logic [111:0]                  o_tlb_ram_write_bus,
  output logic                          o_tlb_ram_output_enable,
  input  wire logic [111:0]             i_tlb_ram_read_bus,
  output logic                          o_force_write_through,
  output logic                          o_instr_linefill_disable,
  output logic                          o_data_linefill_disable,
  output logic                          o_main_tlb_match_off_instr,
  output logic                          o_main_tlb_match_off_data,
  output logic                          o_main_tlb_load_off_instr,
  output logic                          o_main_tlb_load_off_data,
  output logic                          o_instr_micro_match_off,
  output logic                          o_data_micro_match_off,
  output logic                          o_instr_micro_load_off,
  output logic                          o_data_micro_load_off,
  input  wire mcd_pkg::mcd_attr_e       i_instr_cb,
  input  wire mcd_pkg::mcd_attr_e       i_data_cb,
  input  wire logic                     i_d_write_hit,
  output mcd_pkg::mcd_attr_e            o_instr_attr,
  output mcd_pkg::mcd_attr_e            o_data_attr,
  output logic                          o_d_set_dirty,
  output logic                          o_d_write_mem,
  output logic                          o_i_fill_update,
  output logic                          o_d_fill_update
);
  import mcd_pkg::*;

  // ************************************************************
  // decode
  // ************************************************************
  mcd_state_e              state_r;
  mcd_state_e              state_nxt;
  logic [`MCD_CDC_W-1:0]   cache_dbg_r;
  logic [`MCD_TDC_W-1:0]   tlb_dbg_r;
  logic [`MCD_REMAP_W-1:0] remap_r;
  logic [31:0]             tag_store_r;
  logic [31:0]             pa_store_r;
  logic [7:0]              valid_r;
  logic                    read_pa_r;
  logic                    take;
  logic                    wr;
  logic                    rd;
  logic                    op_sel;
  logic                    op_tag_wr;
  logic                    op_pa_wr;
  logic                    op_xfer;
  logic                    op_tag_rd;
  logic                    op_pa_rd;
  logic                    op_cdc;
  logic                    op_tdc;
  logic                    op_remap;

  function automatic logic is_op(input logic [2:0] opc1, input logic [3:0] crm, input logic [2:0] opc2);
    return (i_cp_opc1 == opc1) && (i_cp_crm == crm) && (i_cp_opc2 == opc2);
  endfunction

  // lockdown test operations answer to either of two opc1 codes
  function automatic logic is_lock_op(input logic [3:0] crm);
    return is_op(`MCD_OPC1_LOCK_A, crm, `MCD_OPC2_LOCK) || is_op(`MCD_OPC1_LOCK_B, crm, `MCD_OPC2_LOCK);
  endfunction

  // one 56-bit image, replicated into both halves; lanes 0-1 hold one copy, lanes 2-3 all of the other but its bit 0
  function automatic logic [`MCD_RAM_HALF_W-1:0] pack_entry(input logic [31:0] tag, input logic [31:0] pa);
    return {tag[31:10], tag[3:0], pa[31:10], pa[7:0]};
  endfunction

  always_comb
  begin
    take      = i_cp_req && o_cp_ready && (i_cp_crn == `MCD_CRN_DEBUG);
    wr        = take && i_cp_write;
    rd        = take && !i_cp_write;
    op_sel    = is_op(`MCD_OPC1_TEST, `MCD_CRM_SELECT, `MCD_OPC2_PLAIN);
    op_remap  = is_op(`MCD_OPC1_TEST, `MCD_CRM_REMAP, `MCD_OPC2_PLAIN);
    op_cdc    = is_op(`MCD_OPC1_DEBUG, `MCD_CRM_CACHE_DBG, `MCD_OPC2_PLAIN);
    op_tdc    = is_op(`MCD_OPC1_DEBUG, `MCD_CRM_MMU_DBG, `MCD_OPC2_PLAIN);
    op_tag_wr = wr && is_lock_op(`MCD_CRM_TAG_WR);
    op_pa_wr  = wr && is_lock_op(`MCD_CRM_PA_WR);
    op_xfer   = wr && is_lock_op(`MCD_CRM_XFER);
    op_tag_rd = rd && is_lock_op(`MCD_CRM_TAG_RD);
    op_pa_rd  = rd && is_lock_op(`MCD_CRM_PA_RD);
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      MCD_IDLE:
      begin
        if (op_xfer)
        begin
          state_nxt = MCD_WRITE;
        end
        else if (op_tag_rd || op_pa_rd)
        begin
          state_nxt = MCD_READ;
        end
      end
      MCD_WRITE:  state_nxt = MCD_IDLE;
      MCD_READ:   state_nxt = MCD_SAMPLE;
      MCD_SAMPLE: state_nxt = MCD_IDLE;
      default:    state_nxt = MCD_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_r    <= MCD_IDLE;
      o_cp_ready <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      o_cp_ready <= (state_nxt == MCD_IDLE);
    end
  end

  // ************************************************************
  // ram pins
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_tlb_ram_select            <= 1'b0;
      o_tlb_ram_lane_write_enable <= `MCD_LANES_NONE;
      o_tlb_ram_index             <= 3'h0;
      o_tlb_ram_write_bus         <= 112'h0;
      o_tlb_ram_output_enable     <= 1'b1;
      read_pa_r                   <= 1'b0;
    end
    else
    begin
      o_tlb_ram_output_enable <= 1'b1;
      if (wr && op_sel)
      begin
        o_tlb_ram_index <= i_cp_wdata[`MCD_SEL_IDX_HI:`MCD_SEL_IDX_LO];
      end
      if (op_xfer)
      begin
        o_tlb_ram_select            <= 1'b1;
        o_tlb_ram_lane_write_enable <= `MCD_LANES_ALL;
        o_tlb_ram_write_bus         <= {2{pack_entry(tag_store_r, pa_store_r)}};
      end
      else if (op_tag_rd || op_pa_rd)
      begin
        o_tlb_ram_select            <= 1'b1;
        o_tlb_ram_lane_write_enable <= `MCD_LANES_NONE;
        read_pa_r                   <= op_pa_rd;
      end
      else
      begin
        o_tlb_ram_select            <= 1'b0;
        o_tlb_ram_lane_write_enable <= `MCD_LANES_NONE;
      end
    end
  end

  // ************************************************************
  // storage and control registers
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      tag_store_r <= 32'h0;
      pa_store_r  <= 32'h0;
      valid_r     <= 8'h0;
    end
    else
    begin
      if (op_tag_wr)
      begin
        tag_store_r <= i_cp_wdata;
      end
      if (op_pa_wr)
      begin
        pa_store_r <= i_cp_wdata;
      end
      if (op_xfer)
      begin
        valid_r[o_tlb_ram_index] <= tag_store_r[`MCD_TAG_VALID];
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cache_dbg_r <= `MCD_CDC_RST;
      tlb_dbg_r   <= `MCD_TDC_RST;
      remap_r     <= `MCD_REMAP_RST;
    end
    else if (wr)
    begin
      // upper bits are dropped, so they never steer anything
      if (op_cdc)
      begin
        cache_dbg_r <= i_cp_wdata[`MCD_CDC_W-1:0];
      end
      if (op_tdc)
      begin
        tlb_dbg_r <= i_cp_wdata[`MCD_TDC_W-1:0];
      end
      if (op_remap)
      begin
        remap_r <= i_cp_wdata[`MCD_REMAP_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_force_write_through      <= 1'b0;
      o_instr_linefill_disable   <= 1'b0;
      o_data_linefill_disable    <= 1'b0;
      o_main_tlb_match_off_instr <= 1'b0;
      o_main_tlb_match_off_data  <= 1'b0;
      o_main_tlb_load_off_instr  <= 1'b0;
      o_main_tlb_load_off_data   <= 1'b0;
      o_instr_micro_match_off    <= 1'b0;
      o_data_micro_match_off     <= 1'b0;
      o_instr_micro_load_off     <= 1'b0;
      o_data_micro_load_off      <= 1'b0;
    end
    else
    begin
      o_force_write_through      <= cache_dbg_r[`MCD_CDC_FWT];
      o_instr_linefill_disable   <= cache_dbg_r[`MCD_CDC_I_FILL_OFF];
      o_data_linefill_disable    <= cache_dbg_r[`MCD_CDC_D_FILL_OFF];
      o_main_tlb_match_off_instr <= tlb_dbg_r[`MCD_TDC_I_MAIN_MATCH];
      o_main_tlb_match_off_data  <= tlb_dbg_r[`MCD_TDC_D_MAIN_MATCH];
      o_main_tlb_load_off_instr  <= tlb_dbg_r[`MCD_TDC_I_MAIN_LOAD];
      o_main_tlb_load_off_data   <= tlb_dbg_r[`MCD_TDC_D_MAIN_LOAD];
      o_instr_micro_match_off    <= tlb_dbg_r[`MCD_TDC_I_MICRO_MATCH];
      o_data_micro_match_off     <= tlb_dbg_r[`MCD_TDC_D_MICRO_MATCH];
      o_instr_micro_load_off     <= tlb_dbg_r[`MCD_TDC_I_MICRO_LOAD];
      o_data_micro_load_off      <= tlb_dbg_r[`MCD_TDC_D_MICRO_LOAD];
    end
  end

  // ************************************************************
  // response
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_cp_done  <= 1'b0;
      o_cp_rdata <= 32'h0;
    end
    else
    begin
      o_cp_done <= 1'b0;
      if (state_r == MCD_SAMPLE)
      begin
        // read bus is only looked at here, two edges after the select is raised
        o_cp_done <= 1'b1;
        if (read_pa_r)
        begin
          o_cp_rdata <= {i_tlb_ram_read_bus[29:8], 2'h0, i_tlb_ram_read_bus[7:0]};
        end
        else
        begin
          o_cp_rdata <= {i_tlb_ram_read_bus[55:34], 5'h0, valid_r[o_tlb_ram_index],
                         i_tlb_ram_read_bus[33:30]};
        end
      end
      else if (state_r == MCD_WRITE)
      begin
        o_cp_done <= 1'b1;
      end
      else if (take && !(op_xfer || op_tag_rd || op_pa_rd))
      begin
        o_cp_done  <= 1'b1;
        o_cp_rdata <= 32'h0;
        if (rd && op_cdc)
        begin
          o_cp_rdata <= {29'h0, cache_dbg_r};
        end
        else if (rd && op_tdc)
        begin
          o_cp_rdata <= {24'h0, tlb_dbg_r};
        end
        else if (rd && op_remap)
        begin
          o_cp_rdata <= {16'h0, remap_r};
        end
      end
    end
  end

  mcd_attr_resolve u_attr
  (
    .i_clk                    (i_clk),
    .i_rst_n                  (i_rst_n),
    .i_remap                  (remap_r),
    .i_force_write_through    (cache_dbg_r[`MCD_CDC_FWT]),
    .i_instr_linefill_disable (cache_dbg_r[`MCD_CDC_I_FILL_OFF]),
    .i_data_linefill_disable  (cache_dbg_r[`MCD_CDC_D_FILL_OFF]),
    .i_instr_cb               (i_instr_cb),
    .i_data_cb                (i_data_cb),
    .i_d_write_hit            (i_d_write_hit),
    .o_instr_attr             (o_instr_attr),
    .o_data_attr              (o_data_attr),
    .o_d_set_dirty            (o_d_set_dirty),
    .o_d_write_mem            (o_d_write_mem),
    .o_i_fill_update          (o_i_fill_update),
    .o_d_fill_update          (o_d_fill_update)
  );

  // ************************************************************
  // checks
  // ************************************************************
  sequence ram_read_seq;
    o_tlb_ram_select && (o_tlb_ram_lane_write_enable == 4'h0) ##1 !o_tlb_ram_select ##1 o_cp_done;
  endsequence

  xfer_all_lanes_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    op_xfer |=> o_tlb_ram_select && (o_tlb_ram_lane_write_enable == 4'hf) ##1 o_cp_done && !o_tlb_ram_select)
    else $error("transfer did not write all lanes");

  xfer_image_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    op_xfer |=> o_tlb_ram_write_bus[55:34] == $past(tag_store_r[31:10]) &&
      o_tlb_ram_write_bus[111:90] == o_tlb_ram_write_bus[55:34])
    else $error("write bus image wrong");

  oe_held_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ##1 o_tlb_ram_output_enable)
    else $error("ram output enable dropped");

  ram_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (op_tag_rd || op_pa_rd) |=> ram_read_seq)
    else $error("ram read sequence wrong");

  index_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr && op_sel) |=> o_tlb_ram_index == $past(i_cp_wdata[28:26]))
    else $error("entry index not taken from bits 28:26");

  cdc_reset_a: assert property (@(posedge i_clk)
    !i_rst_n |=> (cache_dbg_r == 3'h0) && (tlb_dbg_r == 8'h0) && (remap_r == 16'he4e4))
    else $error("debug registers not at reset value");

  tdc_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr && op_tdc) |=> ##1 o_main_tlb_match_off_instr == $past(i_cp_wdata[7], 2) &&
      o_data_micro_load_off == $past(i_cp_wdata[0], 2))
    else $error("translation debug outputs not following register");

  resv_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rd && op_cdc) |=> o_cp_done && (o_cp_rdata[31:3] == 29'h0))
    else $error("reserved bits not zero");

endmodule

// ==== tb/mcd_tlb_ram_model.sv ====
// behavioural tlb data ram: lane writes, registered read
`timescale 1ns/1ps
module mcd_tlb_ram_model
(
  input  wire logic         i_clk,
  input  wire logic         i_select,
  input  wire logic [3:0]   i_lane_we,
  input  wire logic [2:0]   i_index,
  input  wire logic [111:0] i_wdata,
  output logic [111:0]      o_rdata
);
  logic [111:0] mem [8];
  initial o_rdata = '0;
  always @(posedge i_clk)
  begin
    if (i_select)
    begin
      if (i_lane_we[0]) mem[i_index][29:0] <= i_wdata[29:0];
      if (i_lane_we[1]) mem[i_index][55:30] <= i_wdata[55:30];
      if (i_lane_we[2]) mem[i_index][85:57] <= i_wdata[85:57];
      if (i_lane_we[3]) mem[i_index][111:86] <= i_wdata[111:86];
      o_rdata <= mem[i_index];
    end
    else
      o_rdata <= ~o_rdata;
  end
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the debug control block
`timescale 1ns/1ps
module tb_top;
  import mcd_pkg::*;
  // ****************
  // signals
  // ****************
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        req = 1'b0;
  logic        wr = 1'b0;
  logic        hit = 1'b1;
  logic [2:0]  o1 = 3'h0;
  logic [2:0]  o2 = 3'h0;
  logic [3:0]  crm = 4'h0;
  logic [3:0]  crn = 4'hf;
  logic [31:0] wd = 32'h0;
  logic [31:0] lf = 32'h10;
  mcd_attr_e   icb = MCD_NCNB;
  mcd_attr_e   dcb = MCD_NCNB;
  logic        ready, done, sel, oe;
  logic [3:0]  we, pol;
  mcd_idx_t    idx;
  logic [111:0] wbus, rbus, img;
  logic [31:0] rdata, rd, x, r, tq [8], pq [8];
  logic [7:0]  tdc;
  logic [2:0]  cdc, o;
  mcd_attr_e   ia, da, ea, eb;
  int          n_fail = 0;
  int          checked = 0;
  int          cyc = 0;
  int          k, c, n;
  always #50 i_clk = ~i_clk;
  mcd_debug_ctrl i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cp_req(req), .i_cp_write(wr), .i_cp_crn(crn),
    .i_cp_opc1(o1), .i_cp_crm(crm), .i_cp_opc2(o2), .i_cp_wdata(wd), .o_cp_ready(ready), .o_cp_done(done),
    .o_cp_rdata(rdata), .o_tlb_ram_select(sel), .o_tlb_ram_lane_write_enable(we), .o_tlb_ram_index(idx),
    .o_tlb_ram_write_bus(wbus), .o_tlb_ram_output_enable(oe), .i_tlb_ram_read_bus(rbus),
    .o_force_write_through(cdc[2]), .o_instr_linefill_disable(cdc[1]), .o_data_linefill_disable(cdc[0]),
    .o_main_tlb_match_off_instr(tdc[7]), .o_main_tlb_match_off_data(tdc[6]), .o_main_tlb_load_off_instr(tdc[5]),
    .o_main_tlb_load_off_data(tdc[4]), .o_instr_micro_match_off(tdc[3]), .o_data_micro_match_off(tdc[2]),
    .o_instr_micro_load_off(tdc[1]), .o_data_micro_load_off(tdc[0]), .i_instr_cb(icb), .i_data_cb(dcb),
    .i_d_write_hit(hit), .o_instr_attr(ia), .o_data_attr(da), .o_d_set_dirty(pol[3]), .o_d_write_mem(pol[2]),
    .o_i_fill_update(pol[1]), .o_d_fill_update(pol[0]));
  mcd_tlb_ram_model i_ram (.i_clk(i_clk), .i_select(sel), .i_lane_we(we), .i_index(idx), .i_wdata(wbus),
    .o_rdata(rbus));
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 16; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  // forced write-through only touches data whose remapped class is cachable
  function automatic mcd_attr_e rmp(input logic [7:0] f, input mcd_attr_e cl, input logic frc);
    logic [1:0] v;
    v = f[2 * int'(cl) +: 2];
    return mcd_attr_e'((frc && v[1]) ? 2'h2 : v);
  endfunction
  task automatic chk(input string nm, input logic [111:0] e, input logic [111:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cp(input logic w, input logic [2:0] a, input logic [3:0] m, input logic [2:0] b,
                    input logic [31:0] d);
    @(negedge i_clk);
    {req, wr, o1, crm, o2, wd} = {1'b1, w, a, m, b, d};
    for (n = 0; n < 8 && ready !== 1'b1; n++) @(negedge i_clk);
    @(negedge i_clk);
    req = 1'b0;
    for (n = 0; n < 8 && done !== 1'b1; n++) @(negedge i_clk);
    chk("cp_done", 1, done);
    rd = rdata;
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  // ****************
  // scenarios
  // ****************
  initial
  begin
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
    // a request for another coprocessor register group must be left alone
    @(negedge i_clk);
    {req, wr, o1, crm, o2, wd, crn} = {1'b1, 1'b1, 3'h7, 4'h0, 3'h0, 32'h7, 4'he};
    @(negedge i_clk);
    req = 1'b0;
    crn = 4'hf;
    chk("foreign_done", 0, done);
    cp(0, 7, 0, 0, 0);
    chk("cdc_rst", 0, rd);
    cp(0, 7, 1, 0, 0);
    chk("tdc_rst", 0, rd);
    cp(0, 0, 2, 0, 0);
    chk("remap_rst", 32'he4e4, rd);
    for (k = 0; k < 24; k++)
    begin
      lf = lfsr(lf);
      x = (k == 0) ? 32'hffffff3f : lf;
      cp(1, 7, 1, 0, x);
      cp(0, 7, 1, 0, 0);
      chk("tdc_rd", x[7:0], rd);
      lf = lfsr(lf);
      r = (k == 1) ? 32'hffffffff : lf;
      cp(1, 7, 0, 0, r);
      cp(0, 7, 0, 0, 0);
      chk("cdc_rd", r[2:0], rd);
      lf = lfsr(lf);
      cp(1, 0, 2, 0, {16'h0, lf[15:0]});
      cp(0, 0, 2, 0, 0);
      chk("remap_rd", lf[15:0], rd);
      @(negedge i_clk);
      chk("tdc_pins", x[7:0], tdc);
      chk("cdc_pins", r[2:0], cdc);
      for (c = 0; c < 4; c++)
      begin
        icb = mcd_attr_e'(c);
        dcb = mcd_attr_e'(3 - c);
        hit = lf[16 + c];
        @(negedge i_clk);
        ea = rmp(lf[15:8], icb, 1'b0);
        eb = rmp(lf[7:0], dcb, r[2]);
        chk("attr", {ea, eb}, {ia, da});
        chk("policy", {hit & (eb == MCD_WB), hit & (eb == MCD_WT), ea[1] & ~r[1], eb[1] & ~r[0]}, pol);
      end
    end
    for (k = 0; k < 8; k++)
    begin
      o = 3'(4 + k % 2);
      tq[k] = lfsr(lf);
      pq[k] = lfsr(tq[k]);
      lf = pq[k];
      cp(1, 0, 1, 0, {3'h0, 3'(k), 26'h0});
      cp(1, o, 3, 1, tq[k]);
      cp(1, o, 5, 1, pq[k]);
      cp(1, o, 7, 1, 0);
      img = {tq[k][31:10], tq[k][3:0], pq[k][31:10], pq[k][7:0]};
      chk("ram_lo", img[55:0], i_ram.mem[k][55:0]);
      chk("ram_hi", img[55:1], i_ram.mem[k][111:57]);
      chk("oe", 1, oe);
    end
    for (k = 7; k >= 0; k--)
    begin
      cp(1, 0, 1, 0, {3'h0, 3'(k), 26'h0});
      cp(0, 4, 2, 1, 0);
      chk("tag_rd", {tq[k][31:10], 5'h0, tq[k][4], tq[k][3:0]}, rd);
      cp(0, 5, 4, 1, 0);
      chk("pa_rd", {pq[k][31:10], 2'h0, pq[k][7:0]}, rd);
    end
    report_and_stop();
  end
endmodule
